// ==== logic/frame_format_decode.sv ====
// per-port character framing decoder for one format code
`timescale 1ns/1ns
`include "serial_station_map.svh"

module frame_format_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] fmt_code,
  output logic data8_r,
  output serial_station_pkg::parity_e parity_r,
  output logic two_stop_r,
  output serial_station_pkg::frame_mode_e mode_r
);
  import serial_station_pkg::*;

  logic data8_nxt;
  parity_e parity_nxt;
  logic two_stop_nxt;
  frame_mode_e mode_nxt;

  // ------------------------------------------------
  // code to framing
  // ------------------------------------------------
  // codes step none/even/odd within each group of three
  always_comb begin
    data8_nxt = (fmt_code >= `FMT_DATA8_FIRST);
    mode_nxt = (fmt_code >= `FMT_RTU_FIRST) ? MODE_RTU : MODE_ASCII;
    case (fmt_code)
      4'h0, 4'h3, 4'h6: parity_nxt = PAR_NONE;
      4'h1, 4'h4, 4'h7: parity_nxt = PAR_EVEN;
      4'h2, 4'h5, 4'h8: parity_nxt = PAR_ODD;
      default: parity_nxt = PAR_NONE;
    endcase
    two_stop_nxt = (parity_nxt == PAR_NONE); // no parity pairs with two stops
  end

  // ------------------------------------------------
  // registered outputs
  // ------------------------------------------------
  // reset shows the default code 6: rtu, 8 data, no parity, 2 stops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data8_r <= 1'b1;
      parity_r <= PAR_NONE;
      two_stop_r <= 1'b1;
      mode_r <= MODE_RTU;
    end else begin
      data8_r <= data8_nxt;
      parity_r <= parity_nxt;
      two_stop_r <= two_stop_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  property p_rtu_is_8bit;
    @(posedge clk) disable iff (rst)
    (fmt_code >= `FMT_RTU_FIRST && fmt_code <= `FMT_CODE_MAX) |=> (mode_r == MODE_RTU) && data8_r;
  endproperty
  a_rtu_is_8bit: assert property (p_rtu_is_8bit) else $error("rtu code not decoded as 8-bit rtu");

  property p_ascii_7bit;
    @(posedge clk) disable iff (rst)
    (fmt_code < `FMT_DATA8_FIRST) |=> (mode_r == MODE_ASCII) && !data8_r;
  endproperty
  a_ascii_7bit: assert property (p_ascii_7bit) else $error("low code not decoded as 7-bit ascii");

  property p_parity_stops;
    @(posedge clk) disable iff (rst)
    (fmt_code == 4'h7) |=> (parity_r == PAR_EVEN) && !two_stop_r;
  endproperty
  a_parity_stops: assert property (p_parity_stops) else $error("code 7 not even parity one stop");

endmodule

// ==== logic/serial_station_config.sv ====
// station address match, per-port baud and framing configuration registers
`timescale 1ns/1ns
`include "serial_station_map.svh"

module serial_station_config #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_wr_err,
  input wire logic [7:0] frame_addr,
  input wire logic frame_addr_valid,
  output logic frame_accept,
  output logic frame_discard,
  output logic frame_broadcast,
  output logic [7:0] station_addr,
  output logic [1:0][15:0] port_baud_div,
  output logic [1:0] port_data8,
  output serial_station_pkg::parity_e [1:0] port_parity,
  output logic [1:0] port_two_stop,
  output serial_station_pkg::frame_mode_e [1:0] port_mode
);
  import serial_station_pkg::*;

  // ------------------------------------------------
  // elaboration check and bit-time counts
  // ------------------------------------------------
  // slowest rate must still fit the 16-bit bit-time count
  if (CLK_HZ < 2 * `BAUD_RATE_5 || (CLK_HZ + `BAUD_RATE_0 / 2) / `BAUD_RATE_0 > 65535) begin : g_bad_clk
    $error("clock rate outside what the bit-time counts can serve");
  end

  // bit time in clock cycles, rounded to nearest
  localparam logic [15:0] BAUD_DIV_0 = 16'((CLK_HZ + `BAUD_RATE_0 / 2) / `BAUD_RATE_0);
  localparam logic [15:0] BAUD_DIV_1 = 16'((CLK_HZ + `BAUD_RATE_1 / 2) / `BAUD_RATE_1);
  localparam logic [15:0] BAUD_DIV_2 = 16'((CLK_HZ + `BAUD_RATE_2 / 2) / `BAUD_RATE_2);
  localparam logic [15:0] BAUD_DIV_3 = 16'((CLK_HZ + `BAUD_RATE_3 / 2) / `BAUD_RATE_3);
  localparam logic [15:0] BAUD_DIV_4 = 16'((CLK_HZ + `BAUD_RATE_4 / 2) / `BAUD_RATE_4);
  localparam logic [15:0] BAUD_DIV_5 = 16'((CLK_HZ + `BAUD_RATE_5 / 2) / `BAUD_RATE_5);

  // baud code to bit-time count
  function automatic logic [15:0] baud_div(input logic [3:0] code);
    case (code)
      4'h0: baud_div = BAUD_DIV_0;
      4'h1: baud_div = BAUD_DIV_1;
      4'h2: baud_div = BAUD_DIV_2;
      4'h3: baud_div = BAUD_DIV_3;
      4'h4: baud_div = BAUD_DIV_4;
      4'h5: baud_div = BAUD_DIV_5;
      default: baud_div = BAUD_DIV_3;
    endcase
  endfunction

  // two per-port digits both within limit, upper byte clear
  function automatic logic digits_ok(input logic [15:0] val, input logic [3:0] max);
    digits_ok = (val[15:8] == 8'h00) && (val[7:4] <= max) && (val[3:0] <= max);
  endfunction

  logic [7:0] station_r;
  logic [7:0] baud_r;
  logic [7:0] fmt_r;
  logic wr_addr;
  logic wr_baud;
  logic wr_fmt;
  logic addr_ok;
  logic baud_ok;
  logic fmt_ok;

  // ------------------------------------------------
  // write decode and value checks
  // ------------------------------------------------
  assign wr_addr = reg_wr && (reg_addr == `OFS_STATION_ADDRESS);
  assign wr_baud = reg_wr && (reg_addr == `OFS_PORT_BAUD_SELECT);
  assign wr_fmt = reg_wr && (reg_addr == `OFS_PORT_FRAME_FORMAT);
  // high digit 0..7, nonzero, so 0xff can never land
  assign addr_ok = (reg_wdata[15:8] == 8'h00) && (reg_wdata[7:4] <= `ADDR_HI_DIGIT_MAX) &&
                   (reg_wdata[7:0] >= `ADDR_MIN);
  assign baud_ok = digits_ok(reg_wdata, `BAUD_CODE_MAX);
  assign fmt_ok = digits_ok(reg_wdata, `FMT_CODE_MAX);

  // ------------------------------------------------
  // station address register
  // ------------------------------------------------
  // out-of-range writes leave the old value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      station_r <= 8'(`RST_STATION_ADDRESS);
    end else if (wr_addr && addr_ok) begin
      station_r <= reg_wdata[7:0];
    end
  end

  // ------------------------------------------------
  // baud and format registers
  // ------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_r <= 8'(`RST_PORT_BAUD_SELECT);
    end else if (wr_baud && baud_ok) begin
      baud_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt_r <= 8'(`RST_PORT_FRAME_FORMAT);
    end else if (wr_fmt && fmt_ok) begin
      fmt_r <= reg_wdata[7:0];
    end
  end

  // refused write flagged for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_err <= 1'b0;
    end else begin
      reg_wr_err <= (wr_addr && !addr_ok) || (wr_baud && !baud_ok) || (wr_fmt && !fmt_ok);
    end
  end

  // ------------------------------------------------
  // register read
  // ------------------------------------------------
  // unmapped offsets read zero, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_STATION_ADDRESS: reg_rdata <= {8'h00, station_r};
          `OFS_PORT_BAUD_SELECT: reg_rdata <= {8'h00, baud_r};
          `OFS_PORT_FRAME_FORMAT: reg_rdata <= {8'h00, fmt_r};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ------------------------------------------------
  // station address match
  // ------------------------------------------------
  // one verdict pulse per offered address byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_accept <= 1'b0;
      frame_discard <= 1'b0;
      frame_broadcast <= 1'b0;
    end else begin
      frame_broadcast <= frame_addr_valid && (frame_addr == `ADDR_BROADCAST);
      frame_accept <= frame_addr_valid &&
                      ((frame_addr == station_r) || (frame_addr == `ADDR_BROADCAST));
      frame_discard <= frame_addr_valid &&
                       (frame_addr != station_r) && (frame_addr != `ADDR_BROADCAST);
    end
  end

  // shared address also handed to the can side
  assign station_addr = station_r;

  // ------------------------------------------------
  // per-port baud and framing
  // ------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int LSB = (p == 0) ? `DIGIT_232_LSB : `DIGIT_485_LSB;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        port_baud_div[p] <= BAUD_DIV_3;
      end else begin
        port_baud_div[p] <= baud_div(baud_r[LSB +: `DIGIT_WIDTH]);
      end
    end

    frame_format_decode u_fmt (
      .clk(clk),
      .rst(rst),
      .fmt_code(fmt_r[LSB +: `DIGIT_WIDTH]),
      .data8_r(port_data8[p]),
      .parity_r(port_parity[p]),
      .two_stop_r(port_two_stop[p]),
      .mode_r(port_mode[p])
    );
  end

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  property p_addr_in_range;
    @(posedge clk) disable iff (rst)
    (station_r >= `ADDR_MIN) && (station_r <= `ADDR_MAX) && (station_r[7:4] <= `ADDR_HI_DIGIT_MAX);
  endproperty
  a_addr_in_range: assert property (p_addr_in_range) else $error("station address out of range");

  property p_bad_addr_refused;
    @(posedge clk) disable iff (rst)
    (wr_addr && (reg_wdata == 16'h00ff || reg_wdata == 16'h0000)) |=> $stable(station_r) && reg_wr_err;
  endproperty
  a_bad_addr_refused: assert property (p_bad_addr_refused) else $error("illegal address accepted");

  property p_good_addr_taken;
    @(posedge clk) disable iff (rst)
    (wr_addr && addr_ok) |=> (station_r == $past(reg_wdata[7:0])) && !reg_wr_err;
  endproperty
  a_good_addr_taken: assert property (p_good_addr_taken) else $error("legal address not stored");

  property p_broadcast_accept;
    @(posedge clk) disable iff (rst)
    (frame_addr_valid && frame_addr == `ADDR_BROADCAST) |=> frame_accept && frame_broadcast && !frame_discard;
  endproperty
  a_broadcast_accept: assert property (p_broadcast_accept) else $error("broadcast frame not accepted");

  property p_own_accept;
    @(posedge clk) disable iff (rst)
    (frame_addr_valid && frame_addr == station_r) |=> frame_accept && !frame_discard;
  endproperty
  a_own_accept: assert property (p_own_accept) else $error("own address frame not accepted");

  property p_other_discard;
    @(posedge clk) disable iff (rst)
    (frame_addr_valid && frame_addr != station_r && frame_addr != `ADDR_BROADCAST)
      |=> frame_discard && !frame_accept;
  endproperty
  a_other_discard: assert property (p_other_discard) else $error("foreign frame not dropped");

  property p_no_verdict_idle;
    @(posedge clk) disable iff (rst)
    !frame_addr_valid |=> !frame_accept && !frame_discard && !frame_broadcast;
  endproperty
  a_no_verdict_idle: assert property (p_no_verdict_idle) else $error("verdict without address");

  property p_baud_485_fast;
    @(posedge clk) disable iff (rst)
    (baud_r[7:4] == 4'h5) |=> (port_baud_div[1] == BAUD_DIV_5);
  endproperty
  a_baud_485_fast: assert property (p_baud_485_fast) else $error("rs-485 baud count wrong");

  property p_baud_232_slow;
    @(posedge clk) disable iff (rst)
    (baud_r[3:0] == 4'h0) |=> (port_baud_div[0] == BAUD_DIV_0);
  endproperty
  a_baud_232_slow: assert property (p_baud_232_slow) else $error("rs-232 baud count wrong");

  property p_fmt_digits_legal;
    @(posedge clk) disable iff (rst)
    (fmt_r[3:0] <= `FMT_CODE_MAX) && (fmt_r[7:4] <= `FMT_CODE_MAX) &&
    (baud_r[3:0] <= `BAUD_CODE_MAX) && (baud_r[7:4] <= `BAUD_CODE_MAX);
  endproperty
  a_fmt_digits_legal: assert property (p_fmt_digits_legal) else $error("port code out of range");

  c_broadcast: cover property (@(posedge clk) disable iff (rst) frame_broadcast);
  c_discard: cover property (@(posedge clk) disable iff (rst) frame_discard);
  c_addr_write: cover property (@(posedge clk) disable iff (rst) wr_addr && addr_ok);
  c_refused: cover property (@(posedge clk) disable iff (rst) reg_wr_err);

endmodule

// ==== logic/serial_station_map.svh ====
// offsets, reset values, limits and timing figures of the serial station block
`ifndef SERIAL_STATION_MAP_SVH
`define SERIAL_STATION_MAP_SVH

// register offsets
`define OFS_STATION_ADDRESS 16'h0300
`define OFS_PORT_BAUD_SELECT 16'h0302
`define OFS_PORT_FRAME_FORMAT 16'h0304

// reset values
`define RST_STATION_ADDRESS 16'h007f
`define RST_PORT_BAUD_SELECT 16'h0033
`define RST_PORT_FRAME_FORMAT 16'h0066

// field positions: digit 0 is the rs-232 port, digit 1 the rs-485 port
`define DIGIT_232_LSB 0
`define DIGIT_485_LSB 4
`define DIGIT_WIDTH 4

// legal ranges
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'h7f
`define ADDR_HI_DIGIT_MAX 4'h7
`define ADDR_BROADCAST 8'hff
`define BAUD_CODE_MAX 4'h5
`define FMT_CODE_MAX 4'h8
`define FMT_RTU_FIRST 4'h6
`define FMT_DATA8_FIRST 4'h3

// timing: clock rate in hz and line rates in bits per second
`define CLK_HZ 100000000
`define BAUD_RATE_0 4800
`define BAUD_RATE_1 9600
`define BAUD_RATE_2 19200
`define BAUD_RATE_3 38400
`define BAUD_RATE_4 57600
`define BAUD_RATE_5 115200

`endif

// ==== logic/serial_station_pkg.sv ====
// types shared by the serial station configuration block
package serial_station_pkg;

  // parity selection, one-hot
  typedef enum logic [2:0] {
    PAR_NONE = 3'b001,
    PAR_EVEN = 3'b010,
    PAR_ODD = 3'b100
  } parity_e;

  // framing family, one-hot
  typedef enum logic [1:0] {
    MODE_ASCII = 2'b01,
    MODE_RTU = 2'b10
  } frame_mode_e;

endpackage

// ==== tb/host_master_model.sv ====
// host-side modbus master model offering station address bytes
`timescale 1ns/1ns

module host_master_model (
  input wire logic clk,
  output logic [7:0] frame_addr,
  output logic frame_addr_valid,
  input wire logic frame_accept,
  input wire logic frame_discard,
  input wire logic frame_broadcast
);
  initial begin
    frame_addr = 8'h00;
    frame_addr_valid = 1'b0;
  end

  // offer one address byte, report {broadcast, discard, accept} one cycle later
  task automatic send(input logic [7:0] a, output logic [2:0] verdict);
    @(negedge clk);
    frame_addr = a; // only one station is ever configured per address
    frame_addr_valid = 1'b1;
    @(negedge clk);
    frame_addr_valid = 1'b0;
    frame_addr = ~a; // released byte no longer shows the last value
    verdict = {frame_broadcast, frame_discard, frame_accept};
  endtask
endmodule

// ==== tb/serial_station_config_test.sv ====
// self-checking bench for the serial station configuration block
`timescale 1ns/1ns
`include "serial_station_map.svh"

module serial_station_config_test;
  import serial_station_pkg::*;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int DIV [6] = '{20833, 10417, 5208, 2604, 1736, 868};
  localparam logic [15:0] ST_VALS [7] = '{16'h0012, 16'h0000, 16'h0080, 16'h00ff, 16'h0112, 16'h0001, 16'h007f};
  localparam bit ST_BAD [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic reg_rvalid, reg_wr_err;
  logic [7:0] frame_addr, station_addr;
  logic frame_addr_valid, frame_accept, frame_discard, frame_broadcast;
  logic [1:0][15:0] port_baud_div;
  logic [1:0] port_data8, port_two_stop;
  parity_e [1:0] port_parity;
  frame_mode_e [1:0] port_mode;
  int error_cnt = 0;
  int n_checks = 0;

  // clock flips every half period
  always #5 clk = ~clk;

  serial_station_config #(.CLK_HZ(100000000)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr_err(reg_wr_err),
    .frame_addr(frame_addr), .frame_addr_valid(frame_addr_valid), .frame_accept(frame_accept),
    .frame_discard(frame_discard), .frame_broadcast(frame_broadcast), .station_addr(station_addr),
    .port_baud_div(port_baud_div), .port_data8(port_data8), .port_parity(port_parity),
    .port_two_stop(port_two_stop), .port_mode(port_mode)
  );

  host_master_model u_host (
    .clk(clk), .frame_addr(frame_addr), .frame_addr_valid(frame_addr_valid),
    .frame_accept(frame_accept), .frame_discard(frame_discard), .frame_broadcast(frame_broadcast)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // one write, returns the refusal pulse; waits until derived outputs settle
  task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic err);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    err = reg_wr_err;
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1, "read valid");
    d = reg_rdata;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [15:0] d;
    logic e;
    rd(`OFS_STATION_ADDRESS, d);
    chk(d, 16'h007f, "station reset");
    rd(`OFS_PORT_BAUD_SELECT, d);
    chk(d, 16'h0033, "baud reset");
    rd(`OFS_PORT_FRAME_FORMAT, d);
    chk(d, 16'h0066, "format reset");
    chk(port_baud_div, {16'd2604, 16'd2604}, "reset divisors");
    chk({port_data8, port_two_stop}, 4'hf, "reset framing bits");
    chk(port_mode, {MODE_RTU, MODE_RTU}, "reset mode");
    chk(port_parity, {PAR_NONE, PAR_NONE}, "reset parity");
    rd(16'h0308, d);
    chk(d, 16'h0000, "unmapped read");
    wr(16'h0308, 16'h1234, e);
    chk(e, 1'b0, "unmapped write");
  endtask

  // legal, boundary and refused station values
  task automatic t_station;
    logic [15:0] d;
    logic e;
    logic [7:0] cur;
    cur = 8'h7f;
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_STATION_ADDRESS, ST_VALS[i], e);
      chk(e, ST_BAD[i], "station refusal");
      if (!ST_BAD[i]) begin
        cur = ST_VALS[i][7:0];
      end
      chk(station_addr, cur, "station port");
      rd(`OFS_STATION_ADDRESS, d);
      chk(d, {8'h00, cur}, "station readback");
    end
  endtask

  // every baud code on both ports, different per port
  task automatic t_baud;
    logic [15:0] d;
    logic e;
    for (int c = 0; c < 6; c++) begin
      wr(`OFS_PORT_BAUD_SELECT, {8'h00, 4'(5 - c), 4'(c)}, e);
      chk(e, 1'b0, "baud accepted");
      chk(port_baud_div[0], DIV[c], "rs232 divisor");
      chk(port_baud_div[1], DIV[5 - c], "rs485 divisor");
    end
    wr(`OFS_PORT_BAUD_SELECT, 16'h0006, e);
    chk(e, 1'b1, "baud digit0 refused");
    wr(`OFS_PORT_BAUD_SELECT, 16'h0060, e);
    chk(e, 1'b1, "baud digit1 refused");
    wr(`OFS_PORT_BAUD_SELECT, 16'h0105, e);
    chk(e, 1'b1, "baud upper byte refused");
    rd(`OFS_PORT_BAUD_SELECT, d);
    chk(d, 16'h0005, "baud kept");
  endtask

  // every format code on both ports
  task automatic t_format;
    logic [15:0] d;
    logic e;
    int k;
    for (int c = 0; c < 9; c++) begin
      wr(`OFS_PORT_FRAME_FORMAT, {8'h00, 4'(8 - c), 4'(c)}, e);
      chk(e, 1'b0, "format accepted");
      for (int p = 0; p < 2; p++) begin
        k = p ? 8 - c : c;
        chk(port_data8[p], k >= 3, "data bits");
        chk(port_parity[p], k % 3 == 0 ? PAR_NONE : k % 3 == 1 ? PAR_EVEN : PAR_ODD, "parity");
        chk(port_two_stop[p], k % 3 == 0, "stop bits");
        chk(port_mode[p], k >= 6 ? MODE_RTU : MODE_ASCII, "mode");
      end
    end
    wr(`OFS_PORT_FRAME_FORMAT, 16'h0009, e);
    chk(e, 1'b1, "format digit0 refused");
    wr(`OFS_PORT_FRAME_FORMAT, 16'h0090, e);
    chk(e, 1'b1, "format digit1 refused");
    wr(`OFS_PORT_FRAME_FORMAT, 16'h0108, e);
    chk(e, 1'b1, "format upper byte refused");
    rd(`OFS_PORT_FRAME_FORMAT, d);
    chk(d, 16'h0008, "format kept");
  endtask

  // reset in mid-run brings back the defaults
  task automatic t_rereset;
    logic [15:0] d;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(station_addr, 8'h7f, "station after reset");
    rd(`OFS_PORT_FRAME_FORMAT, d);
    chk(d, 16'h0066, "format after reset");
    chk(port_mode, {MODE_RTU, MODE_RTU}, "mode after reset");
  endtask

  // own, broadcast and foreign station bytes
  task automatic t_match;
    logic e;
    logic [2:0] v;
    wr(`OFS_STATION_ADDRESS, 16'h0012, e);
    u_host.send(8'h12, v);
    chk(v, 3'b001, "own address");
    u_host.send(8'hff, v);
    chk(v, 3'b101, "broadcast");
    u_host.send(8'h13, v);
    chk(v, 3'b010, "foreign address");
    u_host.send(8'h92, v);
    chk(v, 3'b010, "high bit set");
    u_host.send(8'h7f, v);
    chk(v, 3'b010, "old address");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_station;
    t_baud;
    t_format;
    t_match;
    t_rereset;
    finish_test;
  end

  initial begin
    #100000;
    error_cnt++;
    $display("BAD t=%0t run did not end", $time);
    finish_test;
  end
endmodule
